// file: hw/gsc_pkg.sv
// package: constants for game scoring and end control
package gsc_pkg;
  localparam int unsigned CLK_HZ            = 125_000_000;
  localparam int unsigned GAME_OVER_MS      = 5000;
  localparam int unsigned GAME_OVER_CYC     = (CLK_HZ / 1000) * GAME_OVER_MS;
  localparam int unsigned SERVICE_SLOW      = 50;
  localparam int unsigned THRESH_STEP       = 10;
  localparam int unsigned THRESH_MIN_SEL    = 1;
  localparam int unsigned THRESH_MAX_SEL    = 7;
  localparam logic [2:0]  THRESH_DEF_SEL    = 3'h4;
  localparam int unsigned HR_TARGET_MAX     = 16;
  localparam logic [4:0]  HR_TARGET_DEF     = 5'h01;
  localparam logic [2:0]  HIT_HOME_RUN      = 3'h4;
  localparam logic [2:0]  HIT_TRIPLE        = 3'h3;
  localparam logic [2:0]  HIT_DOUBLE        = 3'h2;
  localparam logic [2:0]  HIT_SINGLE        = 3'h1;
  localparam logic [2:0]  HIT_FOUL          = 3'h0;
  localparam logic [3:0]  BCD_MAX           = 4'h9;
  typedef enum logic [2:0] {
    GSC_HIT_NONE,
    GSC_HIT_FOUL,
    GSC_HIT_SINGLE,
    GSC_HIT_DOUBLE,
    GSC_HIT_TRIPLE,
    GSC_HIT_HOME_RUN
  } gsc_hit_t;
endpackage

// file: hw/gsc_bcd_digit.sv
// module: one bcd decade counter with seven-segment output
`timescale 1ns/1ps
module gsc_bcd_digit (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic       inc,
  output logic [3:0]      digit_q,
  output logic            carry,
  output logic [6:0]      seg_q
);
  // segment order gfedcba, active high
  function automatic logic [6:0] bcd_to_seg(input logic [3:0] v);
    case (v)
      4'h0: bcd_to_seg = 7'h3f;
      4'h1: bcd_to_seg = 7'h06;
      4'h2: bcd_to_seg = 7'h5b;
      4'h3: bcd_to_seg = 7'h4f;
      4'h4: bcd_to_seg = 7'h66;
      4'h5: bcd_to_seg = 7'h6d;
      4'h6: bcd_to_seg = 7'h7d;
      4'h7: bcd_to_seg = 7'h07;
      4'h8: bcd_to_seg = 7'h7f;
      4'h9: bcd_to_seg = 7'h6f;
      default: bcd_to_seg = 7'h00;
    endcase
  endfunction

  assign carry = inc && (digit_q == gsc_pkg::BCD_MAX);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      digit_q <= 4'h0;
    end else if (clear) begin
      digit_q <= 4'h0;
    end else if (inc) begin
      digit_q <= carry ? 4'h0 : digit_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_q <= 7'h00;
    end else begin
      seg_q <= bcd_to_seg(clear ? 4'h0 : (inc ? (carry ? 4'h0 : digit_q + 4'h1) : digit_q));
    end
  end
endmodule // gsc_bcd_digit

// file: hw/gsc_game_scoring.sv
// module: scoring, end-of-game, free-game and service slowdown
// Overview of operation
// - add hit pulse count to batter's score
// - units carry advances tens decade counter
// - second player has separate counter pair
// - each digit drives seven-segment outputs
// - strike pulse accepted as separate input
// - threshold jumper 10 to 70, default 40
// - per-player compare, requests ORed active low
// - end only while first player due up
// - falling edge starts 5 s game-over pulse and one-cycle decrement
// - game over blocks receiver, clears input flop
// - game over selects first player batting
// - game-over edge clears all score digits
// - count each rising home-run indication outside game over, up to 16
// - reaching target 1..16 sets free-game flag
// - free game suppresses games counter decrement
// - clear home-run count before new game unless a home run lands in the clear cycle
// - service jumper slows sequencing about 50x
// - pulse count classifies hit type
`timescale 1ns/1ps
module gsc_game_scoring #(
  parameter int unsigned GAME_OVER_CYCLES = gsc_pkg::GAME_OVER_CYC,
  parameter int unsigned SLOW_FACTOR      = gsc_pkg::SERVICE_SLOW
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        coin_pulse,
  input  wire logic        hit_gate,
  input  wire logic        strike_pulse,
  input  wire logic        second_player_up,
  input  wire logic        batter_toggle,
  input  wire logic        receiver_in_n,
  input  wire logic [2:0]  thresh_sel,
  input  wire logic [4:0]  hr_target,
  input  wire logic        service_mode,
  output logic [3:0]       p1_units_q,
  output logic [3:0]       p1_tens_q,
  output logic [3:0]       p2_units_q,
  output logic [3:0]       p2_tens_q,
  output logic [6:0]       p1_units_seg,
  output logic [6:0]       p1_tens_seg,
  output logic [6:0]       p2_units_seg,
  output logic [6:0]       p2_tens_seg,
  output logic [2:0]       hit_class_q,
  output logic             hit_class_valid_q,
  output logic             strike_seen_q,
  output logic             end_request_n,
  output logic             game_over_q,
  output logic             games_dec_q,
  output logic             receiver_blocked,
  output logic             input_proc_clear,
  output logic             second_player_batting_q,
  output logic [4:0]       hr_count_q,
  output logic             free_game_q,
  output logic             seq_tick
);
  if (GAME_OVER_CYCLES < 1) begin : g_bad_go_len
    $error("game over length must be at least one cycle");
  end
  if (SLOW_FACTOR < 2) begin : g_bad_slow
    $error("slow factor must be at least two");
  end

  // product overflows 32 bits at the default length
  localparam int unsigned GO_W = $clog2(64'(GAME_OVER_CYCLES) * 64'(SLOW_FACTOR) + 64'h1);
  localparam int unsigned SL_W = $clog2(SLOW_FACTOR + 1);

  // pin synchronisers, first stage read only by second
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] pins_raw;
  assign pins_raw = {coin_pulse, hit_gate, strike_pulse, second_player_up,
                     batter_toggle, receiver_in_n, service_mode};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle pin levels: receiver line high, the rest low
      sync1_q <= 7'h02;
      sync2_q <= 7'h02;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end
  logic coin_s, hit_s, strike_s, p2up_s, toggle_s, rx_n_s, svc_s;
  assign {coin_s, hit_s, strike_s, p2up_s, toggle_s, rx_n_s, svc_s} = sync2_q;

  // jumpers are pins too; static in play, so the two-cycle lag is harmless
  logic [2:0] thr_sync1_q;
  logic [2:0] thr_sync2_q;
  logic [4:0] hrt_sync1_q;
  logic [4:0] hrt_sync2_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      thr_sync1_q <= gsc_pkg::THRESH_DEF_SEL;
      thr_sync2_q <= gsc_pkg::THRESH_DEF_SEL;
      hrt_sync1_q <= gsc_pkg::HR_TARGET_DEF;
      hrt_sync2_q <= gsc_pkg::HR_TARGET_DEF;
    end else begin
      thr_sync1_q <= thresh_sel;
      thr_sync2_q <= thr_sync1_q;
      hrt_sync1_q <= hr_target;
      hrt_sync2_q <= hrt_sync1_q;
    end
  end

  logic hit_d1_q, strike_d1_q, toggle_d1_q, coin_d1_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_d1_q    <= 1'b0;
      strike_d1_q <= 1'b0;
      toggle_d1_q <= 1'b0;
      coin_d1_q   <= 1'b0;
    end else begin
      hit_d1_q    <= hit_s;
      strike_d1_q <= strike_s;
      toggle_d1_q <= toggle_s;
      coin_d1_q   <= coin_s;
    end
  end
  logic hit_rise, hit_fall, strike_rise, toggle_rise, coin_rise;
  assign hit_rise    = hit_s && !hit_d1_q;
  assign hit_fall    = !hit_s && hit_d1_q;
  assign strike_rise = strike_s && !strike_d1_q;
  assign toggle_rise = toggle_s && !toggle_d1_q;
  assign coin_rise   = coin_s && !coin_d1_q;

  // service slowdown prescaler; one tick per cycle in normal play
  logic [SL_W-1:0] slow_cnt_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_cnt_q <= '0;
    end else if (!svc_s || slow_cnt_q == SL_W'(SLOW_FACTOR - 1)) begin
      slow_cnt_q <= '0;
    end else begin
      slow_cnt_q <= slow_cnt_q + 1'b1;
    end
  end
  assign seq_tick = !svc_s || (slow_cnt_q == SL_W'(SLOW_FACTOR - 1));

  logic score_clear;
  logic game_over_start;
  logic [2:0] pulse_cnt_q;
  logic [2:0] pending_q;
  logic       cur_p2_q;

  // count the coincidence pulses that arrive during the hit gate
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt_q <= 3'h0;
    end else if (hit_rise) begin
      pulse_cnt_q <= 3'h0;
    end else if (coin_rise && hit_s && pulse_cnt_q != gsc_pkg::HIT_HOME_RUN) begin
      pulse_cnt_q <= pulse_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_class_q       <= gsc_pkg::HIT_FOUL;
      hit_class_valid_q <= 1'b0;
    end else begin
      hit_class_valid_q <= hit_fall;
      if (hit_fall) begin
        hit_class_q <= pulse_cnt_q;
      end
    end
  end

  logic home_run_ev;
  assign home_run_ev = hit_fall && (pulse_cnt_q == gsc_pkg::HIT_HOME_RUN);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strike_seen_q <= 1'b0;
    end else begin
      strike_seen_q <= strike_rise;
    end
  end

  // score pulses feed out one per tick, so slow mode paces them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_q <= 3'h0;
      cur_p2_q  <= 1'b0;
    end else if (score_clear) begin
      pending_q <= 3'h0;
    end else if (hit_fall) begin
      pending_q <= pulse_cnt_q;
      cur_p2_q  <= second_player_batting_q;
    end else if (seq_tick && pending_q != 3'h0) begin
      pending_q <= pending_q - 3'h1;
    end
  end

  logic inc_any, inc_p1, inc_p2, p1_carry, p2_carry;
  assign inc_any = seq_tick && pending_q != 3'h0 && !hit_fall;
  assign inc_p1  = inc_any && !cur_p2_q;
  assign inc_p2  = inc_any && cur_p2_q;

  gsc_bcd_digit u_p1_units (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clear   (score_clear),
    .inc     (inc_p1),
    .digit_q (p1_units_q),
    .carry   (p1_carry),
    .seg_q   (p1_units_seg)
  );

  gsc_bcd_digit u_p1_tens (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clear   (score_clear),
    .inc     (p1_carry),
    .digit_q (p1_tens_q),
    .carry   (),
    .seg_q   (p1_tens_seg)
  );

  gsc_bcd_digit u_p2_units (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clear   (score_clear),
    .inc     (inc_p2),
    .digit_q (p2_units_q),
    .carry   (p2_carry),
    .seg_q   (p2_units_seg)
  );

  gsc_bcd_digit u_p2_tens (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clear   (score_clear),
    .inc     (p2_carry),
    .digit_q (p2_tens_q),
    .carry   (),
    .seg_q   (p2_tens_seg)
  );

  // threshold in tens; out-of-range jumper falls back to default
  logic [2:0] thr_tens;
  assign thr_tens = (thr_sync2_q >= 3'(gsc_pkg::THRESH_MIN_SEL)
                     && thr_sync2_q <= 3'(gsc_pkg::THRESH_MAX_SEL))
                    ? thr_sync2_q : gsc_pkg::THRESH_DEF_SEL;

  function automatic logic reached_n(input logic [3:0] tens, input logic [2:0] thr);
    reached_n = !(tens >= {1'b0, thr});
  endfunction

  logic p1_reached_n, p2_reached_n;
  assign p1_reached_n = reached_n(p1_tens_q, thr_tens);
  assign p2_reached_n = reached_n(p2_tens_q, thr_tens);
  // old scores still stand in the clear cycle and must not restart the pulse
  assign end_request_n = !((!p1_reached_n || !p2_reached_n)
                           && !second_player_batting_q && !game_over_q
                           && !score_clear);

  logic end_req_d1_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      end_req_d1_q <= 1'b1;
    end else begin
      end_req_d1_q <= end_request_n;
    end
  end
  assign game_over_start = end_req_d1_q && !end_request_n;

  // game-over timer, stretched in service mode
  logic [GO_W-1:0] go_cnt_q;
  logic [GO_W-1:0] go_len;
  assign go_len = svc_s ? GO_W'(64'(GAME_OVER_CYCLES) * 64'(SLOW_FACTOR))
                        : GO_W'(GAME_OVER_CYCLES);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      go_cnt_q    <= '0;
      game_over_q <= 1'b0;
    end else if (game_over_start) begin
      go_cnt_q    <= go_len - 1'b1;
      game_over_q <= 1'b1;
    end else if (game_over_q) begin
      if (go_cnt_q == '0) begin
        game_over_q <= 1'b0;
      end else begin
        go_cnt_q <= go_cnt_q - 1'b1;
      end
    end
  end

  // shaped one-cycle decrement at pulse start, vetoed by free game
  logic game_over_d1_q;
  logic game_over_end;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      game_over_d1_q <= 1'b0;
    end else begin
      game_over_d1_q <= game_over_q;
    end
  end
  assign game_over_end = game_over_d1_q && !game_over_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      games_dec_q <= 1'b0;
    end else begin
      games_dec_q <= game_over_start && !free_game_q;
    end
  end

  assign receiver_blocked = game_over_q || rx_n_s;
  assign input_proc_clear = game_over_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_player_batting_q <= 1'b0;
    end else if (game_over_q || game_over_start) begin
      second_player_batting_q <= 1'b0;
    end else if (toggle_rise) begin
      second_player_batting_q <= p2up_s;
    end
  end

  assign score_clear = game_over_end;

  // home-run counting; cleared as game-over pulse ends unless a home run lands in that cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hr_count_q <= 5'h00;
    end else if (home_run_ev && !game_over_q) begin
      if (hr_count_q != 5'(gsc_pkg::HR_TARGET_MAX)) begin
        hr_count_q <= hr_count_q + 5'h01;
      end
    end else if (game_over_end) begin
      hr_count_q <= 5'h00;
    end
  end

  logic [4:0] hr_tgt;
  assign hr_tgt = (hrt_sync2_q >= 5'h01 && hrt_sync2_q <= 5'(gsc_pkg::HR_TARGET_MAX))
                  ? hrt_sync2_q : gsc_pkg::HR_TARGET_DEF;

  // a fresh set wins over the new-game clear; the stale count in the clear cycle does not
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      free_game_q <= 1'b0;
    end else if (!game_over_q && !game_over_end
                 && hr_count_q >= hr_tgt && hr_count_q != 5'h00) begin
      free_game_q <= 1'b1;
    end else if (game_over_end) begin
      free_game_q <= 1'b0;
    end
  end
endmodule // gsc_game_scoring

// file: sim/gsc_properties.sv
// checker: port-level timing relations of scoring and end control
`timescale 1ns/1ps
module gsc_checker #(
  parameter int unsigned GAME_OVER_CYCLES = 20
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       service_mode,
  input wire logic [4:0] hr_target,
  input wire logic [3:0] p1_units_q,
  input wire logic [3:0] p1_tens_q,
  input wire logic [3:0] p2_units_q,
  input wire logic [3:0] p2_tens_q,
  input wire logic       end_request_n,
  input wire logic       game_over_q,
  input wire logic       games_dec_q,
  input wire logic       receiver_blocked,
  input wire logic       input_proc_clear,
  input wire logic       second_player_batting_q,
  input wire logic [4:0] hr_count_q,
  input wire logic       free_game_q,
  input wire logic       seq_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // length counter: repetition of 20+ cycles would be too costly to unroll
  int unsigned go_cnt_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) go_cnt_q <= 0;
    else go_cnt_q <= game_over_q ? go_cnt_q + 1 : 0;
  end
  sequence s_go_start;
    game_over_q && games_dec_q;
  endsequence
  sequence s_cleared;
    {p1_units_q, p1_tens_q, p2_units_q, p2_tens_q} == 16'h0000 && hr_count_q == 5'h00;
  endsequence
  AST_END_QUAL: assert property (!end_request_n |-> !second_player_batting_q && !game_over_q)
    else $error("end request while second player due");
  AST_DEC: assert property (!end_request_n && !free_game_q |=> s_go_start)
    else $error("game over start without decrement");
  AST_NO_DEC: assert property (games_dec_q |-> game_over_q && !free_game_q)
    else $error("decrement outside game over or in free game");
  AST_GO_LEN: assert property ($fell(game_over_q) && !service_mode |-> go_cnt_q == GAME_OVER_CYCLES)
    else $error("game over length wrong");
  AST_BLOCK: assert property (game_over_q |-> receiver_blocked && input_proc_clear)
    else $error("input not blocked in game over");
  AST_FIRST: assert property (game_over_q && $past(game_over_q) |-> !second_player_batting_q)
    else $error("second player selected in game over");
  AST_CLEAR: assert property ($fell(game_over_q) |-> ##[0:2] s_cleared ##1 !free_game_q)
    else $error("scores or home runs not cleared");
  AST_FREE: assert property ($rose(free_game_q) |-> ##[0:1] hr_count_q == hr_target)
    else $error("free game at wrong home run count");
  AST_CARRY: assert property (p2_units_q == 4'h0 && $past(p2_units_q) == 4'h9
    && !$past(game_over_q, 2) && !$past(game_over_q, 3)
    |-> p2_tens_q == ($past(p2_tens_q) == 4'h9 ? 4'h0 : $past(p2_tens_q) + 4'h1))
    else $error("units wrap did not advance tens");
  AST_TICK: assert property (!service_mode && !$past(service_mode, 4) |-> seq_tick)
    else $error("sequencing slowed outside service mode");
endmodule // gsc_checker

bind gsc_game_scoring gsc_checker #(.GAME_OVER_CYCLES(GAME_OVER_CYCLES)) chk_u (
  .ref_clk, .reset_n, .service_mode, .hr_target, .p1_units_q, .p1_tens_q,
  .p2_units_q, .p2_tens_q, .end_request_n, .game_over_q, .games_dec_q,
  .receiver_blocked, .input_proc_clear, .second_player_batting_q,
  .hr_count_q, .free_game_q, .seq_tick
);

// file: sim/gsc_field_model.sv
// partner model: hit coincidence source and games counter
`timescale 1ns/1ps
module gsc_field_model #(
  parameter logic [7:0] GAMES_INIT = 8'h05
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [2:0] count,
  input  wire logic       games_dec_q,
  output logic            hit_gate,
  output logic            coin_pulse,
  output logic            busy,
  output logic [7:0]      games_left
);
  // two-cycle pulses so the input synchroniser sees every edge
  initial begin
    int n;
    hit_gate = 1'b0;
    coin_pulse = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (start === 1'b1) begin
        busy = 1'b1;
        n = count;
        @(negedge ref_clk);
        hit_gate = 1'b1;
        repeat (2) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
          coin_pulse = 1'b1;
          repeat (2) @(negedge ref_clk);
          coin_pulse = 1'b0;
          repeat (2) @(negedge ref_clk);
        end
        hit_gate = 1'b0;
        @(posedge ref_clk);
        busy = 1'b0;
      end
    end
  end
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) games_left <= GAMES_INIT;
    else if (games_dec_q) games_left <= games_left - 8'h01;
  end
endmodule // gsc_field_model

// file: sim/gsc_game_scoring_test.sv
// testbench: hits, game end, free game and service slowdown
`timescale 1ns/1ps
module gsc_game_scoring_test;
  logic       ref_clk = 1'b0;
  logic       reset_n, start, strike_pulse, second_player_up, batter_toggle;
  logic       receiver_in_n, service_mode, hit_gate, coin_pulse, busy, strike_seen_q;
  logic [2:0] cnt, thresh_sel, hit_class_q;
  logic [4:0] hr_target, hr_count_q;
  logic [3:0] p1_units_q, p1_tens_q, p2_units_q, p2_tens_q;
  logic [6:0] p2_tens_seg, p2_units_seg, p1_tens_seg, p1_units_seg;
  logic [7:0] games_left;
  logic       end_request_n, game_over_q, games_dec_q, receiver_blocked;
  logic       input_proc_clear, second_player_batting_q, free_game_q, seq_tick, hit_class_valid_q;
  int         bad_count = 0;
  int         comparisons = 0;
  int         k;
  logic [2:0] h1 [5] = '{3'h3, 3'h1, 3'h0, 3'h4, 3'h2};
  always #4 ref_clk = ~ref_clk;
  gsc_game_scoring #(.GAME_OVER_CYCLES(20), .SLOW_FACTOR(4)) dut_u (
    .ref_clk, .reset_n, .coin_pulse, .hit_gate, .strike_pulse, .second_player_up,
    .batter_toggle, .receiver_in_n, .thresh_sel, .hr_target, .service_mode,
    .p1_units_q, .p1_tens_q, .p2_units_q, .p2_tens_q, .p1_units_seg, .p1_tens_seg,
    .p2_units_seg, .p2_tens_seg, .hit_class_q, .hit_class_valid_q, .strike_seen_q,
    .end_request_n, .game_over_q, .games_dec_q, .receiver_blocked, .input_proc_clear,
    .second_player_batting_q, .hr_count_q, .free_game_q, .seq_tick
  );
  gsc_field_model field_u (
    .ref_clk, .reset_n, .start, .count(cnt), .games_dec_q, .hit_gate, .coin_pulse,
    .busy, .games_left
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic hit(input logic [2:0] n);
    int v;
    start = 1'b1;
    cnt = n;
    cyc(1);
    start = 1'b0;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) cyc(1);
    v = 0;
    repeat (10) begin
      cyc(1);
      if (hit_class_valid_q === 1'b1) v++;
    end
    check(v, 1, "hit valid pulses");
    check(hit_class_q, n, "hit class");
  endtask
  task automatic bat(input logic v);
    second_player_up = v;
    batter_toggle = 1'b1;
    cyc(2);
    batter_toggle = 1'b0;
    cyc(5);
  endtask
  // one whole game-over pulse, expected games left after it
  task automatic over(input logic [7:0] left);
    for (int i = 0; i < 50 && game_over_q !== 1'b1; i++) cyc(1);
    cyc(2);
    check(input_proc_clear & receiver_blocked, 1'b1, "input not blocked");
    check(games_left, left, "games counter");
    for (int i = 0; i < 200 && game_over_q !== 1'b0; i++) cyc(1);
    cyc(3);
    check({p1_tens_q, p1_units_q, p2_tens_q, p2_units_q}, 16'h0000, "scores kept");
    check(hr_count_q, 5'h00, "home runs kept");
    check(free_game_q, 1'b0, "free game kept");
    check(second_player_batting_q, 1'b0, "batter not first");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
  initial begin
    {start, cnt, strike_pulse, second_player_up, batter_toggle, service_mode} = '0;
    receiver_in_n = 1'b0;
    thresh_sel = 3'h1;
    hr_target = 5'h10;
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    cyc(4);
    check(receiver_blocked, 1'b0, "receiver blocked idle");
    receiver_in_n = 1'b1;
    strike_pulse = 1'b1;
    cyc(2);
    strike_pulse = 1'b0;
    k = 0;
    repeat (8) begin
      cyc(1);
      if (strike_seen_q === 1'b1) k++;
    end
    check(k, 1, "strike count");
    bat(1'b1);
    check(second_player_batting_q, 1'b1, "batter select");
    foreach (h1[i]) hit(h1[i]);
    check({p2_tens_q, p2_units_q}, 8'h10, "second score");
    check({p1_tens_q, p1_units_q}, 8'h00, "first score moved");
    check({p2_tens_seg, p2_units_seg}, {7'h06, 7'h3f}, "segments");
    check(end_request_n, 1'b1, "early end");
    check(hr_count_q, 5'h01, "home run count");
    bat(1'b0);
    over(8'h04);
    hr_target = 5'h02;
    hit(3'h4);
    hit(3'h4);
    check({p1_tens_q, p1_units_q}, 8'h08, "first score");
    check({p1_tens_seg, p1_units_seg}, {7'h3f, 7'h7f}, "first segments");
    check(free_game_q, 1'b1, "free game");
    hit(3'h2);
    over(8'h04);
    service_mode = 1'b1;
    cyc(8);
    k = 0;
    repeat (40) begin
      cyc(1);
      if (seq_tick === 1'b1) k++;
    end
    check(k, 10, "service ticks");
    end_sim();
  end
endmodule // gsc_game_scoring_test
